//--- rtl/watchdog_timer_with_postscaler.sv
// Watchdog timer with base counter, 16-bit postscaler and Wishbone registers
`timescale 1ns/1ps

module watchdog_timer_with_postscaler
    import wdt_pkg::*;
(
    // Clock, reset and freeze
    input  wire logic              clock,
    input  wire logic              rstn,
    input  wire logic              ce,
    // Wishbone classic slave
    input  wire logic              wb_cyc_i,
    input  wire logic              wb_stb_i,
    input  wire logic              wb_we_i,
    input  wire logic [ADDR_W-1:0] wb_adr_i,
    input  wire logic [3:0]        wb_sel_i,
    input  wire logic [31:0]       wb_dat_i,
    output logic      [31:0]       wb_dat_o,
    output logic                   wb_ack_o,
    // Slow oscillator tick and its enable
    input  wire logic              lfosc_tick,
    output logic                   low_freq_internal_osc_en,
    // CPU and clock system events
    input  wire cpu_evt_t          cpu_evt,
    input  wire logic              in_sleep,
    input  wire logic [2:0]        internal_osc_freq_select,
    // Time-out outputs
    output logic                   wdt_timeout,
    output logic                   wdt_reset_req,
    output logic                   wdt_wake_req
);

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    logic              sw_en_ff;
    cfg_t              cfg_ff;
    logic              to_flag_ff;
    logic [BASE_W-1:0] base_cnt_ff;
    logic [POST_W-1:0] post_cnt_ff;
    logic [2:0]        osc_sel_ff;
    logic              osc_sel_vld_ff;
    wdt_state_t        state_ff;
    wdt_state_t        nxt_state;
    logic              ack_ff;
    logic [31:0]       rdata_ff;
    logic              timeout_ff;
    logic              reset_req_ff;
    logic              wake_req_ff;
    logic              wdt_run;
    logic              osc_change;
    logic              clear_cnt;
    logic              base_tick;
    logic              expire;
    logic              bus_req;
    logic              wr_lane0;
    logic [POST_W-1:0] tap_mask;

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------

    // Mask of postscaler bits that must all be set for tap n
    function automatic logic [POST_W-1:0] tap_of(input logic [PS_W-1:0] n);
        logic [POST_W-1:0] m;
        m = '0;
        for (int i = 0; i < POST_W - 1; i++) begin
            if (i < int'(n)) begin
                m[i] = 1'b1;
            end
        end
        return m;
    endfunction

    // Read mux shared by every mapped offset
    function automatic logic [31:0] read_word(
        input logic [ADDR_W-1:0] adr,
        input logic              sw_en,
        input cfg_t              cfg,
        input logic              to_flag,
        input logic              run,
        input logic [POST_W-1:0] post
    );
        logic [31:0] d;
        d = '0;
        case (adr)
            OFS_CONTROL: begin
                d[CTRL_SW_EN_BIT] = sw_en;
            end
            OFS_CONFIG_HIGH: begin
                d[CFG_PS_MSB:CFG_EN_BIT] = cfg;
            end
            OFS_STATUS: begin
                d[STAT_TO_BIT]     = to_flag;
                d[STAT_RUN_BIT]    = run;
                d[STAT_OSC_EN_BIT] = run;
            end
            OFS_COUNT: begin
                d[POST_W-1:0] = post;
            end
            default: begin
                d = '0;
            end
        endcase
        return d;
    endfunction

    // ------------------------------------------------------------
    // Enable and clear conditions
    // ------------------------------------------------------------

    // Config bit wins; software bit only counts while it is clear
    assign wdt_run = cfg_ff.wdt_config_enable | sw_en_ff;

    // Oscillator runs whenever the watchdog is on
    assign low_freq_internal_osc_en = wdt_run;

    // A compare before the first sample would fake a change
    assign osc_change = osc_sel_vld_ff &&
                        (internal_osc_freq_select != osc_sel_ff);

    // Every clearing source, the off state and a dropped enable zero both
    // counts; the enable term stops an expiry in the cycle the state lags
    assign clear_cnt = cpu_evt.sleep_exec
                     | cpu_evt.clear_watchdog_instruction
                     | osc_change
                     | cpu_evt.clock_fail
                     | (state_ff == WDT_OFF) | !wdt_run;

    // Base period ends on the last oscillator tick of 4 ms
    assign base_tick = (state_ff == WDT_RUN) && lfosc_tick &&
                       (base_cnt_ff == BASE_LAST);

    // Tap n expires after 2^n base periods
    assign tap_mask = tap_of(cfg_ff.wdt_postscale_select);

    // A clear in the same cycle beats the expiry
    assign expire = base_tick && !clear_cnt &&
                    ((post_cnt_ff & tap_mask) == tap_mask);

    // ------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------
    assign bus_req  = wb_cyc_i && wb_stb_i && !ack_ff;
    assign wr_lane0 = bus_req && wb_we_i && wb_sel_i[0];

    // ------------------------------------------------------------
    // Run state
    // ------------------------------------------------------------

    // Next state follows the effective enable
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            WDT_OFF: begin
                if (wdt_run) begin
                    nxt_state = WDT_RUN;
                end
            end
            WDT_RUN: begin
                if (!wdt_run) begin
                    nxt_state = WDT_OFF;
                end
            end
            default: begin
                nxt_state = WDT_OFF;
            end
        endcase
    end

    // State register
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            state_ff <= WDT_OFF;
        end else if (ce) begin
            state_ff <= nxt_state;
        end
    end

    // ------------------------------------------------------------
    // Counters
    // ------------------------------------------------------------

    // Base counter counts oscillator ticks within one period
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            base_cnt_ff <= '0;
        end else if (ce) begin
            if (clear_cnt) begin
                base_cnt_ff <= '0;
            end else if (lfosc_tick) begin
                if (base_cnt_ff == BASE_LAST) begin
                    base_cnt_ff <= '0;
                end else begin
                    base_cnt_ff <= base_cnt_ff + 7'h01;
                end
            end
        end
    end

    // Postscaler counts base periods; restarts on expiry
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            post_cnt_ff <= '0;
        end else if (ce) begin
            if (clear_cnt || expire) begin
                post_cnt_ff <= '0;
            end else if (base_tick) begin
                post_cnt_ff <= post_cnt_ff + 16'h0001;
            end
        end
    end

    // Last seen frequency select, taken after reset release
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            osc_sel_ff     <= 3'h0;
            osc_sel_vld_ff <= 1'b0;
        end else if (ce) begin
            osc_sel_ff     <= internal_osc_freq_select;
            osc_sel_vld_ff <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Time-out outputs
    // ------------------------------------------------------------

    // One pulse per expiry; sleep picks wake instead of reset
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            timeout_ff   <= 1'b0;
            reset_req_ff <= 1'b0;
            wake_req_ff  <= 1'b0;
        end else if (ce) begin
            timeout_ff   <= expire;
            reset_req_ff <= expire && !in_sleep;
            wake_req_ff  <= expire && in_sleep;
        end
    end

    assign wdt_timeout   = timeout_ff;
    assign wdt_reset_req = reset_req_ff;
    assign wdt_wake_req  = wake_req_ff;

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------

    // Software enable; upper bits are not stored
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            sw_en_ff <= CTRL_RESET;
        end else if (ce) begin
            if (wr_lane0 && wb_adr_i == OFS_CONTROL) begin
                sw_en_ff <= wb_dat_i[CTRL_SW_EN_BIT];
            end
        end
    end

    // Configuration byte holds tap select and hard enable
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            cfg_ff <= CFG_RESET;
        end else if (ce) begin
            if (wr_lane0 && wb_adr_i == OFS_CONFIG_HIGH) begin
                cfg_ff <= wb_dat_i[CFG_PS_MSB:CFG_EN_BIT];
            end
        end
    end

    // Time-out flag: write one clears, a new expiry wins
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            to_flag_ff <= 1'b0;
        end else if (ce) begin
            if (expire) begin
                to_flag_ff <= 1'b1;
            end else if (wr_lane0 && wb_adr_i == OFS_STATUS &&
                         wb_dat_i[STAT_TO_BIT]) begin
                to_flag_ff <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // Wishbone answer
    // ------------------------------------------------------------

    // Ack one cycle after the request, dropped the cycle after;
    // this costs a wait state but keeps read data registered
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            ack_ff   <= 1'b0;
            rdata_ff <= '0;
        end else if (ce) begin
            ack_ff <= bus_req;
            if (bus_req && !wb_we_i) begin
                rdata_ff <= read_word(wb_adr_i, sw_en_ff, cfg_ff,
                                      to_flag_ff, wdt_run, post_cnt_ff);
            end else begin
                rdata_ff <= '0;
            end
        end
    end

    assign wb_ack_o = ack_ff;
    assign wb_dat_o = rdata_ff;

endmodule

//--- rtl/wdt_pkg.sv
// Shared constants and types for the watchdog timer with postscaler
package wdt_pkg;

    // ------------------------------------------------------------
    // Register map (byte addresses on the Wishbone bus)
    // ------------------------------------------------------------
    localparam int         ADDR_W          = 4;
    localparam logic [3:0] OFS_CONTROL     = 4'h0;
    localparam logic [3:0] OFS_CONFIG_HIGH = 4'h4;
    localparam logic [3:0] OFS_STATUS      = 4'h8;
    localparam logic [3:0] OFS_COUNT       = 4'hC;

    // ------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------
    localparam int         CTRL_SW_EN_BIT  = 0;
    localparam int         CFG_EN_BIT      = 0;
    localparam int         CFG_PS_LSB      = 1;
    localparam int         CFG_PS_MSB      = 4;
    localparam int         STAT_TO_BIT     = 0;
    localparam int         STAT_RUN_BIT    = 1;
    localparam int         STAT_OSC_EN_BIT = 2;
    localparam logic       CTRL_RESET      = 1'h0;
    localparam logic [4:0] CFG_RESET       = 5'h1F;

    // ------------------------------------------------------------
    // Timing: base period counted in oscillator ticks
    // ------------------------------------------------------------
    localparam int         LFOSC_HZ        = 31250;
    localparam int         BASE_PERIOD_MS  = 4;
    localparam int         BASE_TICKS      = (LFOSC_HZ * BASE_PERIOD_MS) / 1000;
    localparam int         BASE_W          = 7;
    localparam logic [6:0] BASE_LAST       = 7'(BASE_TICKS - 1);
    localparam int         POST_W          = 16;
    localparam int         PS_W            = 4;
    localparam int         LONGEST_TO_MS   = 131072;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef struct packed {
        logic [3:0] wdt_postscale_select;
        logic       wdt_config_enable;
    } cfg_t;

    typedef struct packed {
        logic sleep_exec;
        logic clear_watchdog_instruction;
        logic clock_fail;
    } cpu_evt_t;

    typedef enum logic [1:0] {
        WDT_OFF = 2'h1,
        WDT_RUN = 2'h2
    } wdt_state_t;

endpackage

//--- verification/watchdog_timer_with_postscaler_tb.sv
// Self-checking bench for the watchdog timer with postscaler
`timescale 1ns/1ps
module watchdog_timer_with_postscaler_tb
    import wdt_pkg::*;
();
    // ------
    // Signals and counters
    // ------
    logic              clock, rstn, ce, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, sl;
    logic [ADDR_W-1:0] wb_adr_i;
    logic [3:0]        wb_sel_i;
    logic [31:0]       wb_dat_i, wb_dat_o, q;
    logic              lfosc_tick, low_freq_internal_osc_en, in_sleep;
    cpu_evt_t          cpu_evt;
    logic [2:0]        internal_osc_freq_select;
    logic              wdt_timeout, wdt_reset_req, wdt_wake_req;
    int                error_cnt = 0, samples_checked = 0, to_cnt, wk_cnt, rs_cnt, n, r;

    watchdog_timer_with_postscaler i_watchdog_timer_with_postscaler (
        .clock, .rstn, .ce, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
        .wb_dat_i, .wb_dat_o, .wb_ack_o, .lfosc_tick, .low_freq_internal_osc_en,
        .cpu_evt, .in_sleep, .internal_osc_freq_select, .wdt_timeout,
        .wdt_reset_req, .wdt_wake_req
    );

    // Clock and a hang limit well above the longest expected run
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end
    initial begin
        repeat (40000) @(posedge clock);
        error_cnt++;
        stop_test();
    end
    // Count pulses mid-cycle, where they are settled
    always @(negedge clock) begin
        if (wdt_timeout === 1'b1) to_cnt++;
        if (wdt_wake_req === 1'b1) wk_cnt++;
        if (wdt_reset_req === 1'b1) rs_cnt++;
    end

    // ------
    // Tasks and expectations
    // ------
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Ack and read data are taken at the rising edge that sees ack high;
    // a hang is left to the bench's own cycle limit
    task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
        @(posedge clock);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= w;
        wb_adr_i <= a;
        wb_dat_i <= d;
        do begin
            @(posedge clock);
        end while (wb_ack_o !== 1'b1);
        q = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask
    // Oscillator ticks with random freeze cycles between them
    task automatic ticks(input int k);
        repeat (k) begin
            @(posedge clock);
            lfosc_tick <= 1'b0;
            ce <= ($urandom % 4) != 0;
            @(posedge clock);
            ce <= 1'b1;
            lfosc_tick <= 1'b1;
        end
        @(posedge clock);
        lfosc_tick <= 1'b0;
    endtask
    // Sources 0..2 pulse one event bit, 3 changes the oscillator select
    task automatic clr(input int src);
        @(posedge clock);
        if (src < 3) cpu_evt <= cpu_evt_t'(3'(1 << src));
        else internal_osc_freq_select <= internal_osc_freq_select + 3'h1;
        @(posedge clock);
        cpu_evt <= cpu_evt_t'(3'h0);
    endtask
    function automatic logic [31:0] stat(input logic to, input logic run);
        return {29'h0, run, run, to};
    endfunction
    task automatic stop_test();
        $display("Comparisons %0d, mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // ------
    // Main sequence
    // ------
    initial begin
        {rstn, wb_cyc_i, wb_stb_i, wb_we_i, lfosc_tick, in_sleep} = '0;
        {ce, wb_adr_i, wb_sel_i, wb_dat_i} = {1'b1, 4'h0, 4'hF, 32'h0};
        {cpu_evt, internal_osc_freq_select} = 6'h00;
        void'($urandom(32'hA1EA9B88));
        repeat (12) @(posedge clock);
        rstn <= 1'b1;
        wb(0, OFS_CONTROL, 0);
        check(q, 32'h0);
        wb(0, OFS_CONFIG_HIGH, 0);
        check(q, 32'(CFG_RESET));
        wb(0, OFS_STATUS, 0);
        check(q, stat(0, 1));
        wb(0, 4'h2, 0);
        check(q, 32'h0);
        wb(1, OFS_CONTROL, 32'hFF);
        wb(0, OFS_CONTROL, 0);
        check(q, 32'h1);
        // A write without byte lane 0 must leave the enable alone
        wb_sel_i <= 4'hE;
        wb(1, OFS_CONTROL, 32'h0);
        wb_sel_i <= 4'hF;
        wb(0, OFS_CONTROL, 0);
        check(q, 32'h1);
        wb(1, OFS_CONFIG_HIGH, 32'h0);
        wb(0, OFS_STATUS, 0);
        check(q, stat(0, 1));
        wb(1, OFS_CONTROL, 32'h0);
        wb(0, OFS_STATUS, 0);
        check(q, stat(0, 0));
        check(32'(low_freq_internal_osc_en), 32'h0);
        to_cnt = 0;
        ticks(BASE_TICKS);
        repeat (2) @(negedge clock);
        check(to_cnt, 0);
        wb(1, OFS_CONTROL, 32'h1);
        check(32'(low_freq_internal_osc_en), 32'h1);
        // Two taps per clear source; a failed clear shows as an early expiry
        for (int i = 0; i < 8; i++) begin
            n = i / 2;
            sl = 1'($urandom % 2);
            in_sleep <= sl;
            wb(1, OFS_CONFIG_HIGH, {27'h0, 4'(n), 1'($urandom % 2)});
            r = $urandom_range((BASE_TICKS << n) - 1, 0);
            ticks(r);
            wb(0, OFS_COUNT, 0);
            check(q, r / BASE_TICKS);
            clr(i % 4);
            wb(0, OFS_COUNT, 0);
            check(q, 32'h0);
            {to_cnt, wk_cnt, rs_cnt} = '0;
            ticks((BASE_TICKS << n) - 1);
            repeat (2) @(negedge clock);
            check(to_cnt, 0);
            ticks(1);
            repeat (2) @(negedge clock);
            check(to_cnt, 1);
            check(wk_cnt, sl);
            check(rs_cnt, !sl);
        end
        wb(0, OFS_STATUS, 0);
        check(q, stat(1, 1));
        wb(1, OFS_STATUS, 32'h1);
        wb(0, OFS_STATUS, 0);
        check(q, stat(0, 1));
        stop_test();
    end
endmodule

//--- verification/wdt_checker_asserts.sv
// Checker of bus handshake, expiry and clear timing of the watchdog
`timescale 1ns/1ps
module wdt_checker
    import wdt_pkg::*;
(
    // Clock, reset and freeze
    input wire logic        clock,
    input wire logic        rstn,
    input wire logic        ce,
    // Register bus
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    // Events and time-out outputs
    input wire logic        low_freq_internal_osc_en,
    input wire cpu_evt_t    cpu_evt,
    input wire logic        in_sleep,
    input wire logic [2:0]  internal_osc_freq_select,
    input wire logic        wdt_timeout,
    input wire logic        wdt_reset_req,
    input wire logic        wdt_wake_req
);
    default clocking @(posedge clock); endclocking
    default disable iff (!rstn);
    // ------
    // Bus handshake
    // ------
    bus_answer_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o && ce |=> wb_ack_o)
        else $error("bus request not answered next cycle");
    ack_single_a: assert property (wb_ack_o && ce |=> !wb_ack_o)
        else $error("bus ack longer than one cycle");
    dat_idle_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
        else $error("read data not zero outside ack");
    // ------
    // Expiry and clears
    // ------
    osc_follow_a: assert property (wdt_timeout |-> $past(low_freq_internal_osc_en))
        else $error("expiry without oscillator enable");
    expiry_pulse_a: assert property (wdt_timeout && ce |=> !wdt_timeout)
        else $error("time-out longer than one cycle");
    steer_reset_a: assert property (wdt_timeout |-> wdt_wake_req == $past(in_sleep)
        && wdt_reset_req == !$past(in_sleep))
        else $error("expiry steered wrongly");
    steer_only_a: assert property (wdt_reset_req || wdt_wake_req |-> wdt_timeout)
        else $error("reset or wake without time-out");
    clear_cancel_a: assert property (ce && cpu_evt != 3'h0 |=> !wdt_timeout)
        else $error("expiry after clear event");
    osc_clear_a: assert property (ce && $changed(internal_osc_freq_select) |=> !wdt_timeout)
        else $error("expiry after oscillator select change");
endmodule

bind watchdog_timer_with_postscaler wdt_checker i_wdt_checker (
    .clock, .rstn, .ce, .wb_cyc_i, .wb_stb_i, .wb_dat_o, .wb_ack_o,
    .low_freq_internal_osc_en, .cpu_evt, .in_sleep, .internal_osc_freq_select,
    .wdt_timeout, .wdt_reset_req, .wdt_wake_req
);
